// *** shared/oad_defines.svh ***
// constants for the overhead add/drop port
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
`define OAD_LINK_CLK_HZ 83333333
`define OAD_SDCC_CLK_HZ 216000
`define OAD_LDCC_CLK_HZ 2160000
`define OAD_UCH_CLK_HZ 72000
`define OAD_SDCC_BYTES 4'h3
`define OAD_LDCC_BYTES 4'h9
`define OAD_UCH_BYTES 4'h1
`define OAD_ID_D1 4'h0
`define OAD_ID_D3 4'h2
`define OAD_ID_D4 4'h3
`define OAD_ID_D12 4'hB
`define OAD_ID_F1 4'hC
`define OAD_ID_F2 4'hD
`define OAD_ADD_FILL 8'h00
`define OAD_RING_AW 4
`define OAD_CNT_W 11
`endif

// *** shared/oad_pkg.sv ***
// types for the overhead add/drop port
package oad_pkg;
    typedef enum logic [1:0] {
        CH_SDCC = 2'b00,
        CH_LDCC = 2'b01,
        CH_SUC = 2'b10,
        CH_PUC = 2'b11
    } oad_chan_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LO = 3'b010,
        ST_HI = 3'b100
    } oad_st_t;
endpackage : oad_pkg

// *** hdl/oad_port.sv ***
// overhead add/drop serial port: core rings and link-side bit engines
`timescale 1ns/100ps
`include "oad_defines.svh"
// Functional notes
// - one channel added and one dropped at a time, from four channel kinds
// - add and drop channel selections are independent of each other
// - port bit clocks pulse only for bits of the selected channel
// - section data channel: bytes D1-D3, 216 kHz gapped clock
// - line data channel: bytes D4-D12, 2.16 MHz gapped clock
// - line data channel add clock is high one third of its period
// - section user channel: byte F1, 72 kHz gapped clock
// - path user channel: byte F2, 72 kHz gapped clock
// - add clock is a driven differential output; partner drives add data
// - drop data and drop clock are driven differential outputs
// - separate transmit and receive frame pulses, one per frame
module oad_port
    import oad_pkg::*;
(
    input wire logic i_clk, // core clock
    input wire logic i_arst_n, // async reset
    input wire logic i_lclk, // port clock domain
    input wire logic i_add_en, // add enable
    input wire oad_chan_t i_add_sel, // added channel
    input wire logic i_drop_en, // drop enable
    input wire oad_chan_t i_drop_sel, // dropped channel
    input wire logic i_tx_frame, // tx frame start pulse
    input wire logic i_tx_slot, // tx overhead slot strobe
    input wire logic [3:0] i_tx_id, // tx slot byte id
    input wire logic i_rx_frame, // rx frame start pulse
    input wire logic i_rx_slot, // rx overhead slot strobe
    input wire logic [3:0] i_rx_id, // rx slot byte id
    input wire logic [7:0] i_rx_byte, // rx slot byte
    output logic o_add_valid, // insert byte now
    output logic [7:0] o_add_byte, // byte to insert
    input wire logic i_add_data_p, // added data +
    input wire logic i_add_data_n, // added data -
    output logic o_tx_clk_p, // add clock +
    output logic o_tx_clk_n, // add clock -
    output logic o_rx_data_p, // dropped data +
    output logic o_rx_data_n, // dropped data -
    output logic o_rx_clk_p, // drop clock +
    output logic o_rx_clk_n, // drop clock -
    output logic o_tx_fp, // tx frame pulse
    output logic o_rx_fp // rx frame pulse
);
    localparam int PER_SDCC = `OAD_LINK_CLK_HZ / `OAD_SDCC_CLK_HZ;
    localparam int PER_LDCC = `OAD_LINK_CLK_HZ / `OAD_LDCC_CLK_HZ;
    localparam int PER_UCH = `OAD_LINK_CLK_HZ / `OAD_UCH_CLK_HZ;
    localparam int TX_HI_LDCC = PER_LDCC / 3;
    localparam int RW = `OAD_RING_AW;
    localparam int CW = `OAD_CNT_W;

    function automatic logic chan_hit(oad_chan_t s, logic [3:0] id);
        unique case (s)
            CH_SDCC: chan_hit = (id >= `OAD_ID_D1) && (id <= `OAD_ID_D3);
            CH_LDCC: chan_hit = (id >= `OAD_ID_D4) && (id <= `OAD_ID_D12);
            CH_SUC: chan_hit = (id == `OAD_ID_F1);
            CH_PUC: chan_hit = (id == `OAD_ID_F2);
        endcase
    endfunction : chan_hit

    function automatic logic [CW-1:0] per_of(oad_chan_t s);
        unique case (s)
            CH_SDCC: per_of = CW'(PER_SDCC);
            CH_LDCC: per_of = CW'(PER_LDCC);
            default: per_of = CW'(PER_UCH);
        endcase
    endfunction : per_of

    function automatic logic [3:0] bytes_of(oad_chan_t s);
        unique case (s)
            CH_SDCC: bytes_of = `OAD_SDCC_BYTES;
            CH_LDCC: bytes_of = `OAD_LDCC_BYTES;
            default: bytes_of = `OAD_UCH_BYTES;
        endcase
    endfunction : bytes_of

    // ---------------- core domain ----------------
    logic [7:0] amem [2**RW];
    logic [7:0] dmem [2**RW];
    logic [RW-1:0] awr_q, ard_q, dwr_q, drd_q;
    logic [7:0] dhold_q, thold_q;
    logic dack_q, dpend_q, tfp_tog_q, rfp_tog_q;
    logic [2:0] tbyte_s_q, rreq_s_q;
    logic ttog_q, rreq_q;
    logic tx_hit, rx_hit, tbyte_ev, rreq_ev;

    assign tx_hit = i_add_en && i_tx_slot && chan_hit(i_add_sel, i_tx_id);
    assign rx_hit = i_drop_en && i_rx_slot && chan_hit(i_drop_sel, i_rx_id);
    assign tbyte_ev = tbyte_s_q[1] ^ tbyte_s_q[2];
    assign rreq_ev = rreq_s_q[1] ^ rreq_s_q[2];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tbyte_s_q <= 3'h0;
            rreq_s_q <= 3'h0;
        end else begin
            tbyte_s_q <= {tbyte_s_q[1:0], ttog_q};
            rreq_s_q <= {rreq_s_q[1:0], rreq_q};
        end
    end

    // frame events cross as toggles
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tfp_tog_q <= 1'b0;
            rfp_tog_q <= 1'b0;
        end else begin
            tfp_tog_q <= tfp_tog_q ^ i_tx_frame;
            rfp_tog_q <= rfp_tog_q ^ i_rx_frame;
        end
    end

    // add ring: filled from the port, drained at selected tx slots
    always_ff @(posedge i_clk) begin
        if (tbyte_ev) begin
            amem[awr_q] <= thold_q;
        end
        if (rx_hit) begin
            dmem[dwr_q] <= i_rx_byte;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            awr_q <= '0;
            ard_q <= '0;
            o_add_valid <= 1'b0;
            o_add_byte <= `OAD_ADD_FILL;
        end else begin
            o_add_valid <= tx_hit;
            if (tbyte_ev) begin
                awr_q <= awr_q + 1'b1;
            end
            if (tx_hit) begin
                o_add_byte <= (awr_q != ard_q) ? amem[ard_q] : `OAD_ADD_FILL;
                if (awr_q != ard_q) begin
                    ard_q <= ard_q + 1'b1;
                end
            end
        end
    end

    // drop ring: filled at selected rx slots, served to the port on request
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dwr_q <= '0;
            drd_q <= '0;
            dpend_q <= 1'b0;
            dack_q <= 1'b0;
            dhold_q <= 8'h00;
        end else begin
            if (rx_hit) begin
                dwr_q <= dwr_q + 1'b1;
            end
            if ((dpend_q || rreq_ev) && (dwr_q != drd_q)) begin
                dhold_q <= dmem[drd_q];
                drd_q <= drd_q + 1'b1;
                dack_q <= ~dack_q;
                dpend_q <= 1'b0;
            end else if (rreq_ev) begin
                dpend_q <= 1'b1;
            end
        end
    end

    // ---------------- link domain ----------------
    logic [1:0] lrst_q;
    logic lrst_n;
    logic [1:0] din_p_q, din_n_q, aen_q, den_q;
    logic [1:0] asel0_q, asel1_q, dsel0_q, dsel1_q;
    logic [2:0] tfp_s_q, rfp_s_q, dack_s_q;
    oad_chan_t add_sel_s, drop_sel_s;
    logic din, tfp_ev, rfp_ev, dack_ev;
    logic [CW-1:0] t_per, t_hi, r_per, r_hi;

    assign lrst_n = lrst_q[1];
    assign add_sel_s = oad_chan_t'({asel1_q[1], asel0_q[1]});
    assign drop_sel_s = oad_chan_t'({dsel1_q[1], dsel0_q[1]});
    assign din = din_p_q[1] & ~din_n_q[1];
    assign tfp_ev = tfp_s_q[1] ^ tfp_s_q[2];
    assign rfp_ev = rfp_s_q[1] ^ rfp_s_q[2];
    assign dack_ev = dack_s_q[1] ^ dack_s_q[2];
    assign t_per = per_of(add_sel_s);
    assign t_hi = (add_sel_s == CH_LDCC) ? CW'(TX_HI_LDCC) : (t_per >> 1);
    assign r_per = per_of(drop_sel_s);
    assign r_hi = r_per >> 1;

    always_ff @(posedge i_lclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lrst_q <= 2'b00;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end

    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            din_p_q <= 2'b00;
            din_n_q <= 2'b11;
            aen_q <= 2'b00;
            den_q <= 2'b00;
            asel0_q <= 2'b00;
            asel1_q <= 2'b00;
            dsel0_q <= 2'b00;
            dsel1_q <= 2'b00;
            tfp_s_q <= 3'h0;
            rfp_s_q <= 3'h0;
            dack_s_q <= 3'h0;
        end else begin
            din_p_q <= {din_p_q[0], i_add_data_p};
            din_n_q <= {din_n_q[0], i_add_data_n};
            aen_q <= {aen_q[0], i_add_en};
            den_q <= {den_q[0], i_drop_en};
            asel0_q <= {asel0_q[0], i_add_sel[0]};
            asel1_q <= {asel1_q[0], i_add_sel[1]};
            dsel0_q <= {dsel0_q[0], i_drop_sel[0]};
            dsel1_q <= {dsel1_q[0], i_drop_sel[1]};
            tfp_s_q <= {tfp_s_q[1:0], tfp_tog_q};
            rfp_s_q <= {rfp_s_q[1:0], rfp_tog_q};
            dack_s_q <= {dack_s_q[1:0], dack_q};
        end
    end

    // add engine: clock in one frame's bytes after each tx frame pulse
    oad_st_t tst_q;
    logic [CW-1:0] tcnt_q;
    logic [2:0] tbit_q;
    logic [7:0] tsh_q;
    logic [3:0] tleft_q;
    logic tclk_q;

    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            tst_q <= ST_IDLE;
            tcnt_q <= '0;
            tbit_q <= 3'h0;
            tsh_q <= 8'h00;
            tleft_q <= 4'h0;
            tclk_q <= 1'b0;
            thold_q <= 8'h00;
            ttog_q <= 1'b0;
        end else begin
            if (tfp_ev) begin
                tleft_q <= aen_q[1] ? bytes_of(add_sel_s) : 4'h0;
            end
            unique case (tst_q)
                ST_IDLE: begin
                    if (tleft_q != 4'h0 && !tfp_ev) begin
                        tst_q <= ST_LO;
                        tcnt_q <= t_per - t_hi - 1'b1;
                        tbit_q <= 3'h0;
                    end
                end
                ST_LO: begin
                    if (tcnt_q == '0) begin
                        tclk_q <= 1'b1;
                        tsh_q <= {tsh_q[6:0], din};
                        tcnt_q <= t_hi - 1'b1;
                        tst_q <= ST_HI;
                    end else begin
                        tcnt_q <= tcnt_q - 1'b1;
                    end
                end
                ST_HI: begin
                    if (tcnt_q == '0) begin
                        tclk_q <= 1'b0;
                        if (tbit_q == 3'h7) begin
                            thold_q <= tsh_q;
                            ttog_q <= ~ttog_q;
                            if (!tfp_ev) begin
                                tleft_q <= tleft_q - 1'b1;
                            end
                            tst_q <= ST_IDLE;
                        end else begin
                            tbit_q <= tbit_q + 1'b1;
                            tcnt_q <= t_per - t_hi - 1'b1;
                            tst_q <= ST_LO;
                        end
                    end else begin
                        tcnt_q <= tcnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // drop engine: fetch a byte, shift it out MSB first
    oad_st_t rst_q;
    logic [CW-1:0] rcnt_q;
    logic [2:0] rbit_q;
    logic [7:0] rsh_q;
    logic rclk_q, rdat_q, rwait_q;

    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            rst_q <= ST_IDLE;
            rcnt_q <= '0;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            rclk_q <= 1'b0;
            rdat_q <= 1'b0;
            rwait_q <= 1'b0;
            rreq_q <= 1'b0;
        end else begin
            unique case (rst_q)
                ST_IDLE: begin
                    if (dack_ev) begin
                        rsh_q <= dhold_q;
                        rdat_q <= dhold_q[7];
                        rbit_q <= 3'h0;
                        rcnt_q <= r_per - r_hi - 1'b1;
                        rwait_q <= 1'b0;
                        rst_q <= ST_LO;
                    end else if (!rwait_q && den_q[1]) begin
                        rreq_q <= ~rreq_q;
                        rwait_q <= 1'b1;
                    end
                end
                ST_LO: begin
                    if (rcnt_q == '0) begin
                        rclk_q <= 1'b1;
                        rcnt_q <= r_hi - 1'b1;
                        rst_q <= ST_HI;
                    end else begin
                        rcnt_q <= rcnt_q - 1'b1;
                    end
                end
                ST_HI: begin
                    if (rcnt_q == '0) begin
                        rclk_q <= 1'b0;
                        if (rbit_q == 3'h7) begin
                            rst_q <= ST_IDLE;
                        end else begin
                            rbit_q <= rbit_q + 1'b1;
                            rsh_q <= {rsh_q[6:0], 1'b0};
                            rdat_q <= rsh_q[6];
                            rcnt_q <= r_per - r_hi - 1'b1;
                            rst_q <= ST_LO;
                        end
                    end else begin
                        rcnt_q <= rcnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // pin stage: differential pairs and frame pulses
    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            o_tx_clk_p <= 1'b0;
            o_tx_clk_n <= 1'b1;
            o_rx_clk_p <= 1'b0;
            o_rx_clk_n <= 1'b1;
            o_rx_data_p <= 1'b0;
            o_rx_data_n <= 1'b1;
            o_tx_fp <= 1'b0;
            o_rx_fp <= 1'b0;
        end else begin
            o_tx_clk_p <= tclk_q;
            o_tx_clk_n <= ~tclk_q;
            o_rx_clk_p <= rclk_q;
            o_rx_clk_n <= ~rclk_q;
            o_rx_data_p <= rdat_q;
            o_rx_data_n <= ~rdat_q;
            o_tx_fp <= tfp_ev;
            o_rx_fp <= rfp_ev;
        end
    end

    // assertion helpers
    logic [CW-1:0] thi_q, rper_q;
    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            thi_q <= '0;
            rper_q <= '0;
        end else begin
            thi_q <= o_tx_clk_p ? thi_q + 1'b1 : '0;
            rper_q <= (o_rx_clk_p && !$past(o_rx_clk_p)) ? CW'(1) : rper_q + 1'b1;
        end
    end

    sequence s_tx_rise;
        $rose(o_tx_clk_p);
    endsequence
    sequence s_rx_rise;
        $rose(o_rx_clk_p);
    endsequence

    a_tx_clk_gap: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        s_tx_rise |-> $past(tst_q) == ST_HI && $past(tleft_q) != 4'h0)
        else $error("add clock pulsed outside a selected byte");
    a_rx_clk_gap: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        s_rx_rise |-> $past(rst_q) == ST_HI)
        else $error("drop clock pulsed outside a byte");
    a_ldcc_duty: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        $fell(o_tx_clk_p) && add_sel_s == CH_LDCC |-> thi_q == TX_HI_LDCC)
        else $error("line data add clock high time wrong");
    a_rx_period: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        (s_rx_rise and (rbit_q != 3'h0)) |-> rper_q == r_per)
        else $error("drop clock period wrong for channel");
    a_diff_pairs: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        o_tx_clk_p != o_tx_clk_n && o_rx_clk_p != o_rx_clk_n && o_rx_data_p != o_rx_data_n)
        else $error("differential pair not complementary");
    a_rx_data_edge: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        $changed(o_rx_data_p) |-> !o_rx_clk_p)
        else $error("drop data moved while clock high");
    a_fp_single: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        o_tx_fp |=> !o_tx_fp ##1 !o_tx_fp)
        else $error("tx frame pulse too long");
    a_rx_fp_cause: assert property (@(posedge i_lclk) disable iff (!lrst_n)
        rfp_ev |=> o_rx_fp)
        else $error("rx frame pulse missing");
    a_add_slot: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_add_valid |-> $past(i_add_en && i_tx_slot && chan_hit(i_add_sel, i_tx_id)))
        else $error("insert outside a selected add slot");
    a_drop_slot: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_rx_slot && i_drop_en && chan_hit(i_drop_sel, i_rx_id) |=> dwr_q == $past(dwr_q) + 1'b1)
        else $error("selected drop byte not captured");
endmodule : oad_port

// *** verification/oad_partner.sv ***
// far-end overhead equipment model: feeds added bits, collects dropped bytes
`timescale 1ns/100ps
module oad_partner (
    input wire logic i_tx_clk_p, // add clock from port
    input wire logic i_tx_fp, // tx frame pulse
    input wire logic i_rx_clk_p, // drop clock from port
    input wire logic i_rx_data_p, // dropped data
    input wire logic i_rx_fp, // rx frame pulse
    output logic o_add_data_p, // added data +
    output logic o_add_data_n // added data -
);
    logic [7:0] add_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] sh_q = 8'h00;
    logic bit_q = 1'b0;
    int tx_idx = 0;
    int rx_idx = 0;

    assign o_add_data_p = bit_q;
    assign o_add_data_n = ~bit_q;

    // no byte queued: line keeps changing so a stale bit never looks valid
    task automatic drive_bit();
        if (add_q.size() != 0) begin
            bit_q = add_q[0][7 - tx_idx];
        end else begin
            bit_q = ~bit_q;
        end
    endtask : drive_bit

    always @(posedge i_tx_fp) begin
        tx_idx = 0;
        drive_bit();
    end

    // next bit after each falling edge of the add clock
    always @(negedge i_tx_clk_p) begin
        tx_idx++;
        if (tx_idx == 8) begin
            tx_idx = 0;
            if (add_q.size() != 0) begin
                void'(add_q.pop_front());
            end
        end
        drive_bit();
    end

    always @(posedge i_rx_fp) begin
        rx_idx = 0;
    end

    always @(posedge i_rx_clk_p) begin
        sh_q = {sh_q[6:0], i_rx_data_p};
        rx_idx++;
        if (rx_idx == 8) begin
            rx_idx = 0;
            rx_q.push_back(sh_q);
        end
    end
endmodule : oad_partner

// *** verification/tb_oad_port.sv ***
// self-checking bench for the overhead add/drop port
`timescale 1ns/100ps
module tb_oad_port
    import oad_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_lclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_add_en = 1'b0;
    logic i_drop_en = 1'b0;
    oad_chan_t i_add_sel = CH_SDCC;
    oad_chan_t i_drop_sel = CH_SDCC;
    logic i_tx_frame = 1'b0;
    logic i_tx_slot = 1'b0;
    logic [3:0] i_tx_id = 4'h0;
    logic i_rx_frame = 1'b0;
    logic i_rx_slot = 1'b0;
    logic [3:0] i_rx_id = 4'h0;
    logic [7:0] i_rx_byte = 8'h00;
    logic o_add_valid, o_tx_clk_p, o_tx_clk_n, o_rx_data_p, o_rx_data_n;
    logic o_rx_clk_p, o_rx_clk_n, o_tx_fp, o_rx_fp, add_p, add_n;
    logic [7:0] o_add_byte;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int rises[2];
    int hi_cnt[2];
    int lo_cnt[2];
    int fps[2];
    logic last_clk[2] = '{1'b0, 1'b0};
    logic [7:0] exp_add[$];
    logic [7:0] exp_drop[$];
    logic pend_v = 1'b0;
    logic [7:0] pend_b = 8'h00;
    logic [7:0] b;

    oad_port oad_port_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_lclk(i_lclk),
        .i_add_en(i_add_en), .i_add_sel(i_add_sel), .i_drop_en(i_drop_en),
        .i_drop_sel(i_drop_sel), .i_tx_frame(i_tx_frame), .i_tx_slot(i_tx_slot),
        .i_tx_id(i_tx_id), .i_rx_frame(i_rx_frame), .i_rx_slot(i_rx_slot),
        .i_rx_id(i_rx_id), .i_rx_byte(i_rx_byte), .o_add_valid(o_add_valid),
        .o_add_byte(o_add_byte), .i_add_data_p(add_p), .i_add_data_n(add_n),
        .o_tx_clk_p(o_tx_clk_p), .o_tx_clk_n(o_tx_clk_n), .o_rx_data_p(o_rx_data_p),
        .o_rx_data_n(o_rx_data_n), .o_rx_clk_p(o_rx_clk_p), .o_rx_clk_n(o_rx_clk_n),
        .o_tx_fp(o_tx_fp), .o_rx_fp(o_rx_fp));

    oad_partner oad_partner_inst (.i_tx_clk_p(o_tx_clk_p), .i_tx_fp(o_tx_fp),
        .i_rx_clk_p(o_rx_clk_p), .i_rx_data_p(o_rx_data_p), .i_rx_fp(o_rx_fp),
        .o_add_data_p(add_p), .o_add_data_n(add_n));

    always #2.5 i_clk = ~i_clk;
    always #6 i_lclk = ~i_lclk;

    function automatic int nb(input oad_chan_t c);
        return c == CH_SDCC ? 3 : (c == CH_LDCC ? 9 : 1);
    endfunction : nb

    function automatic logic hit(input oad_chan_t c, input logic [3:0] id);
        case (c)
            CH_SDCC: return id <= 4'h2;
            CH_LDCC: return id >= 4'h3 && id <= 4'hB;
            CH_SUC: return id == 4'hC;
            default: return id == 4'hD;
        endcase
    endfunction : hit

    function automatic int hi_of(input oad_chan_t c, input int k);
        case (c)
            CH_SDCC: return 192;
            CH_LDCC: return k == 0 ? 12 : 19;
            default: return 578;
        endcase
    endfunction : hi_of

    function automatic int per_of(input oad_chan_t c);
        return c == CH_SDCC ? 385 : (c == CH_LDCC ? 38 : 1157);
    endfunction : per_of

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 105000) begin
            err_count++;
            results();
        end
    end

    // pin monitor: pair polarity, frame pulses, gapped clock shape
    always @(posedge i_lclk) begin
        if (i_arst_n) begin
            check({13'h0000, o_tx_clk_n, o_rx_data_n, o_rx_clk_n},
                {13'h0000, ~o_tx_clk_p, ~o_rx_data_p, ~o_rx_clk_p});
            fps[0] += o_tx_fp;
            fps[1] += o_rx_fp;
            for (int k = 0; k < 2; k++) begin
                oad_chan_t s;
                logic v;
                s = k ? i_drop_sel : i_add_sel;
                v = k ? o_rx_clk_p : o_tx_clk_p;
                if (v && !last_clk[k]) begin
                    rises[k]++;
                    check({15'h0000, lo_cnt[k] >= per_of(s) - hi_of(s, k)}, 16'h0001);
                    lo_cnt[k] = 0;
                end
                if (!v && last_clk[k]) begin
                    check(16'(hi_cnt[k]), 16'(hi_of(s, k)));
                    hi_cnt[k] = 0;
                end
                if (v) hi_cnt[k]++;
                else lo_cnt[k]++;
                last_clk[k] = v;
            end
        end
    end

    // one core slot; checks the answer to the previous one
    task automatic tx_step(input logic sl, input logic [3:0] id);
        @(negedge i_clk);
        check({15'h0000, o_add_valid}, {15'h0000, pend_v});
        if (pend_v) check({8'h00, o_add_byte}, {8'h00, pend_b});
        i_tx_slot = sl;
        i_tx_id = id;
        pend_v = sl && i_add_en && hit(i_add_sel, id);
        pend_b = exp_add.size() != 0 ? exp_add[0] : 8'h00;
        if (pend_v && exp_add.size() != 0) void'(exp_add.pop_front());
    endtask : tx_step

    task automatic run(input oad_chan_t a, input oad_chan_t d, input logic en);
        @(negedge i_clk);
        i_add_sel = a;
        i_drop_sel = d;
        i_add_en = en;
        i_drop_en = en;
        rises = '{0, 0};
        repeat (10) @(negedge i_clk);
        for (int i = 0; i < nb(a) && en; i++) begin
            b = 8'($urandom);
            exp_add.push_back(b);
            oad_partner_inst.add_q.push_back(b);
        end
        i_tx_frame = 1'b1;
        i_rx_frame = 1'b1;
        @(negedge i_clk);
        i_tx_frame = 1'b0;
        i_rx_frame = 1'b0;
        repeat (20) @(negedge i_clk);
        for (int i = 0; i < 16; i++) begin
            @(negedge i_clk);
            i_rx_slot = 1'b1;
            i_rx_id = 4'(i);
            i_rx_byte = 8'($urandom);
            if (en && hit(d, i_rx_id)) exp_drop.push_back(i_rx_byte);
        end
        @(negedge i_clk);
        i_rx_slot = 1'b0;
        for (int w = 0; w < 30000; w++) begin
            @(negedge i_clk);
            if (oad_partner_inst.rx_q.size() == exp_drop.size() && rises[0] == 8 * nb(a) * en
                && !o_tx_clk_p && !o_rx_clk_p && (en || w > 1000)) break;
        end
        repeat (100) @(negedge i_clk);
        check(16'(rises[0]), 16'(8 * nb(a) * en));
        check(16'(rises[1]), 16'(8 * exp_drop.size()));
        while (exp_drop.size() > 0) begin
            check({8'h00, oad_partner_inst.rx_q.pop_front()}, {8'h00, exp_drop.pop_front()});
        end
        for (int i = 0; i < 17; i++) begin
            if ($urandom % 2) tx_step(1'b0, 4'h0);
            tx_step(1'b1, i < 16 ? 4'(i) : (a == CH_SDCC ? 4'h0 : 4'h3));
        end
        tx_step(1'b0, 4'h0);
    endtask : run

    initial begin
        void'($urandom(32'h1b91_bba7));
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (10) @(negedge i_clk);
        run(CH_LDCC, CH_SUC, 1'b1);
        run(CH_SDCC, CH_PUC, 1'b1);
        run(CH_PUC, CH_LDCC, 1'b1);
        run(CH_SUC, CH_SDCC, 1'b1);
        run(CH_LDCC, CH_LDCC, 1'b0);
        check(16'(fps[0]), 16'h0005);
        check(16'(fps[1]), 16'h0005);
        results();
    end
endmodule : tb_oad_port
